// ### dcp_host_model.sv
// serial host model: frames 16-bit words onto the three-wire link
`timescale 1ns/1ps
`default_nettype none
module dcp_host_model #(
  parameter realtime HALF = 62.5  // half period of the link clock in ns
) (
  input  wire logic        clk_i,
  input  wire logic        send_i,     // start one frame
  input  wire logic [15:0] word_i,     // word to shift out
  input  wire logic [4:0]  nbits_i,    // bits sent; fewer than 16 aborts
  output logic             sclk_o,     // link clock, still and high between frames
  output logic             serial_data_o,   // serial data
  output logic             frame_sync_n_o,  // frame sync, active low
  output logic             busy_o      // frame in progress
);
  // one frame per request; the link clock runs only inside frames
  initial begin
    sclk_o = 1'b1;
    serial_data_o = 1'b0;
    frame_sync_n_o = 1'b1;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i iff send_i);
      busy_o <= 1'b1;
      #(HALF) frame_sync_n_o = 1'b0;
      // msb first, each bit settled a quarter period before the fall
      for (int i = 15; i > 15 - int'(nbits_i); i--) begin
        #(HALF / 2) serial_data_o = word_i[i];
        #(HALF / 2) sclk_o = 1'b0;
        #(HALF) sclk_o = 1'b1;
      end
      #(HALF) frame_sync_n_o = 1'b1;
      // released line must not keep showing the last bit
      serial_data_o = ~serial_data_o;
      @(posedge clk_i);
      busy_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### dcp_pkg.sv
// shared constants, offsets and types of the dds control block
`default_nettype none
package dcp_pkg;

  // datapath widths
  localparam int ACC_W  = 28;  // phase accumulator
  localparam int PH_W   = 12;  // phase word
  localparam int WORD_W = 16;  // serial word length
  localparam int HALF_W = 14;  // frequency half carried by one word
  localparam int CNT_W  = $clog2(WORD_W);

  // avalon byte offsets, one 32-bit word each
  localparam logic [4:0] OFS_CTRL    = 5'h00;
  localparam logic [4:0] OFS_FREQ_A  = 5'h04;
  localparam logic [4:0] OFS_FREQ_B  = 5'h08;
  localparam logic [4:0] OFS_PHASE_A = 5'h0c;
  localparam logic [4:0] OFS_PHASE_B = 5'h10;
  localparam logic [4:0] OFS_STATUS  = 5'h14;

  // serial word layout: target in the top two bits
  localparam int         TGT_POS    = 14;
  localparam int         PH_SEL_POS = 13;
  localparam logic [1:0] TGT_CTRL   = 2'h0;
  localparam logic [1:0] TGT_FREQ_A = 2'h1;
  localparam logic [1:0] TGT_FREQ_B = 2'h2;
  localparam logic [1:0] TGT_PHASE  = 2'h3;

  // control word, bit 0 is pin_mode
  typedef struct packed {
    logic freq_half_hi;           // serial freq load goes to upper half
    logic logic_output_source;    // 1 comparator, 0 nco msb
    logic logic_output_enable;    // drive the logic output pin
    logic dac_powerdown_bit;      // dac sleep request
    logic phase_word_select_bit;  // phase word b when set
    logic freq_word_select_bit;   // frequency word b when set
    logic pin_mode;               // selects come from the pins
  } dcp_ctrl_t;

  // pins after synchronisation
  typedef struct packed {
    logic comp;       // comparator result
    logic frame_sync_n;    // frame sync, active low
    logic serial_data_in;  // serial data
    logic sclk;       // serial clock
    logic sleep;      // dac sleep pin
    logic reset;      // datapath reset pin, active high
    logic phase_pin;  // phase word select pin
    logic freq_pin;   // frequency word select pin
  } dcp_pins_t;

  // reset values
  localparam dcp_ctrl_t         CTRL_RST  = '0;
  localparam logic [ACC_W-1:0]  FREQ_RST  = 28'h0;
  localparam logic [PH_W-1:0]   PHASE_RST = 12'h0;
  localparam logic [7:0]        PINS_RST  = 8'h40;  // frame sync idles high

endpackage
`default_nettype wire

// ### dcp_serial_rx.sv
// three-wire serial word receiver on synchronised pins
`timescale 1ns/1ps
`default_nettype none
module dcp_serial_rx
  import dcp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              sclk_i,
  input  wire logic              serial_data_in_i,
  input  wire logic              frame_sync_n_i,
  output logic [WORD_W-1:0]      word_o,
  output logic                   word_valid_o
);

  logic              sclk_d;   // previous serial clock
  logic              sync_d;   // previous frame sync
  logic              active;   // inside a frame
  logic [CNT_W-1:0]  cnt;      // bits taken so far
  logic [WORD_W-1:0] shreg;    // msb-first shifter
  logic [4:0]        nfall;    // helper for checks only

  wire sclk_fall   = sclk_d & ~sclk_i;
  wire frame_start = sync_d & ~frame_sync_n_i;
  wire last_bit    = (cnt == CNT_W'(WORD_W - 1));
  wire [WORD_W-1:0] next_shreg = {shreg[WORD_W-2:0], serial_data_in_i};

  // edge detect, count and shift; a short frame is dropped
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_d <= 1'b0;
      sync_d <= 1'b1;
      active <= 1'b0;
      cnt <= '0;
      shreg <= '0;
      word_o <= '0;
      word_valid_o <= 1'b0;
    end else begin
      sclk_d <= sclk_i;
      sync_d <= frame_sync_n_i;
      word_valid_o <= 1'b0;
      if (frame_start) begin
        active <= 1'b1;
        cnt <= '0;
      end else if (frame_sync_n_i) begin
        active <= 1'b0;
      end else if (active && sclk_fall) begin
        shreg <= next_shreg;
        cnt <= cnt + 1'b1;
        if (last_bit) begin
          word_o <= next_shreg;
          word_valid_o <= 1'b1;
          active <= 1'b0;
        end
      end
    end
  end

  // falling edges seen since the frame began
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) nfall <= '0;
    else if (frame_start) nfall <= '0;
    else if (sclk_fall && !frame_sync_n_i && nfall != 5'h1f) nfall <= nfall + 5'h01;
  end

  a_word_bits: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    word_valid_o |-> nfall == 5'h10) else $error("word without sixteen clock falls");
  a_frame_restart: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    frame_start |=> cnt == '0 && active) else $error("frame start did not restart count");
  a_msb_first: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    word_valid_o |-> word_o[0] == $past(serial_data_in_i)) else $error("last bit not in lsb");

endmodule
`default_nettype wire

// ### dcp_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module dcp_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;  // first stage, read only by q_o

  // plain two-stage shift
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= RST;
      q_o  <= RST;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule
`default_nettype wire

// ### dcp_top.sv
// dds control logic: pins, serial load, nco and avalon registers
`timescale 1ns/1ps
`default_nettype none
// Operation
// - pin mode: select pin picks frequency word
// - selected phase word added to accumulator
// - reset pin zeroes accumulator and phase
// - reset leaves host registers untouched
// - sleep pin high powers dac down
// - sleep pin or bit powers dac down
// - each serial word is sixteen bits
// - data taken on serial clock falling edge
// - frame sync falling starts a word
// - logic pin driven only when enabled
// - source bit picks comparator or nco msb
// - enable and source connect comparator pin
// - oscillator runs on the master clock
// - 28-bit modulo accumulator adds every cycle the reset pin is low
// - 12-bit phase added to accumulator msbs
// - select pins sampled on master clock rise
module dcp_top
  import dcp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        freq_word_select_pin_i,
  input  wire logic        phase_word_select_pin_i,
  input  wire logic        dds_reset_i,
  input  wire logic        sleep_i,
  input  wire logic        serial_clk_i,
  input  wire logic        serial_data_in_i,
  input  wire logic        frame_sync_n_i,
  input  wire logic        comparator_result_i,
  output logic [PH_W-1:0]  phase_o,
  output logic             dac_sleep_o,
  output logic             logic_out_o,
  output logic             logic_out_oe_o,
  output logic             comparator_input_pin_o
);

  // merge a bus write into a word by byte lane
  // lanes left out of the enable keep their old bits
  function automatic logic [31:0] merge_be(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // replace one half of a frequency word
  function automatic logic [ACC_W-1:0] put_half(
    input logic [ACC_W-1:0]  old_v,
    input logic              hi,
    input logic [HALF_W-1:0] v
  );
    return hi ? {v, old_v[HALF_W-1:0]} : {old_v[ACC_W-1:HALF_W], v};
  endfunction

  // ---------------- pin synchronisation ----------------

  dcp_pins_t pins_raw;  // pins as they arrive
  dcp_pins_t pins_s;    // pins after two flops
  logic [7:0] pins_q;   // synchroniser output vector

  assign pins_raw = '{comp:      comparator_result_i,
                      frame_sync_n:   frame_sync_n_i,
                      serial_data_in: serial_data_in_i,
                      sclk:      serial_clk_i,
                      sleep:     sleep_i,
                      reset:     dds_reset_i,
                      phase_pin: phase_word_select_pin_i,
                      freq_pin:  freq_word_select_pin_i};

  // every pin, serial clock included, crosses in here
  // a pin that moves close to an edge may land one cycle
  // late; the selects and the link both tolerate that
  dcp_sync #(
    .W   (8),
    .RST (PINS_RST)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (pins_raw),
    .q_o     (pins_q)
  );

  assign pins_s = dcp_pins_t'(pins_q);

  // ---------------- serial receiver ----------------
  // the link clock is only seen through the synchroniser,
  // so each of its halves must span at least three edges

  logic [WORD_W-1:0] ser_word;   // last complete word
  logic              ser_valid;  // one-cycle pulse per word

  dcp_serial_rx u_rx (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .sclk_i       (pins_s.sclk),
    .serial_data_in_i (pins_s.serial_data_in),
    .frame_sync_n_i   (pins_s.frame_sync_n),
    .word_o       (ser_word),
    .word_valid_o (ser_valid)
  );

  // ---------------- host registers ----------------
  // all of them sit on the master clock; the reset pin
  // never reaches them, only the datapath below

  dcp_ctrl_t        ctrl;     // control word
  logic [ACC_W-1:0] freq_a;   // frequency word a
  logic [ACC_W-1:0] freq_b;   // frequency word b
  logic [PH_W-1:0]  phase_a;  // phase word a
  logic [PH_W-1:0]  phase_b;  // phase word b

  // serial word decode, only whole words arrive here
  wire [1:0] ser_tgt = ser_word[TGT_POS +: 2];
  wire ser_ctrl = ser_valid && ser_tgt == TGT_CTRL;
  wire ser_fa   = ser_valid && ser_tgt == TGT_FREQ_A;
  wire ser_fb   = ser_valid && ser_tgt == TGT_FREQ_B;
  wire ser_ph   = ser_valid && ser_tgt == TGT_PHASE;
  wire ser_pb   = ser_word[PH_SEL_POS];  // phase b target
  wire [HALF_W-1:0] ser_half = ser_word[HALF_W-1:0];

  // avalon handshake: one wait cycle, then the answer
  // waitrequest is combinational, so the master sees it
  // in the very cycle that it raises read or write
  logic ack;  // answer cycle, waitrequest low
  wire  req      = avs_read_i | avs_write_i;
  wire  bus_take = req & ~ack;
  wire  bus_wr   = ack & avs_write_i;

  // bus write decode by byte offset
  wire wr_ctrl = bus_wr && avs_address_i == OFS_CTRL;
  wire wr_fa   = bus_wr && avs_address_i == OFS_FREQ_A;
  wire wr_fb   = bus_wr && avs_address_i == OFS_FREQ_B;
  wire wr_pa   = bus_wr && avs_address_i == OFS_PHASE_A;
  wire wr_pb   = bus_wr && avs_address_i == OFS_PHASE_B;

  // merged bus values per register
  wire [31:0] m_ctrl = merge_be(32'(ctrl), avs_writedata_i, avs_byteenable_i);
  wire [31:0] m_fa = merge_be(32'(freq_a), avs_writedata_i, avs_byteenable_i);
  wire [31:0] m_fb = merge_be(32'(freq_b), avs_writedata_i, avs_byteenable_i);
  wire [31:0] m_pa = merge_be(32'(phase_a), avs_writedata_i, avs_byteenable_i);
  wire [31:0] m_pb = merge_be(32'(phase_b), avs_writedata_i, avs_byteenable_i);

  // next values: a serial word wins over a bus write to
  // the same register, since the serial side cannot wait
  dcp_ctrl_t        next_ctrl;
  logic [ACC_W-1:0] next_freq_a;
  logic [ACC_W-1:0] next_freq_b;
  logic [PH_W-1:0]  next_phase_a;
  logic [PH_W-1:0]  next_phase_b;

  assign next_ctrl = ser_ctrl ? dcp_ctrl_t'(ser_word[$bits(dcp_ctrl_t)-1:0])
                   : wr_ctrl ? dcp_ctrl_t'(m_ctrl[$bits(dcp_ctrl_t)-1:0]) : ctrl;
  assign next_freq_a = ser_fa ? put_half(freq_a, ctrl.freq_half_hi, ser_half)
                     : wr_fa ? m_fa[ACC_W-1:0] : freq_a;
  assign next_freq_b = ser_fb ? put_half(freq_b, ctrl.freq_half_hi, ser_half)
                     : wr_fb ? m_fb[ACC_W-1:0] : freq_b;
  assign next_phase_a = (ser_ph && !ser_pb) ? ser_word[PH_W-1:0]
                      : wr_pa ? m_pa[PH_W-1:0] : phase_a;
  assign next_phase_b = (ser_ph && ser_pb) ? ser_word[PH_W-1:0]
                      : wr_pb ? m_pb[PH_W-1:0] : phase_b;

  // host registers ignore the reset pin on purpose
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl    <= CTRL_RST;
      freq_a  <= FREQ_RST;
      freq_b  <= FREQ_RST;
      phase_a <= PHASE_RST;
      phase_b <= PHASE_RST;
    end else begin
      ctrl    <= next_ctrl;
      freq_a  <= next_freq_a;
      freq_b  <= next_freq_b;
      phase_a <= next_phase_a;
      phase_b <= next_phase_b;
    end
  end

  // ---------------- oscillator datapath ----------------
  // select pins reach the sum two edges after they move
  // and the accumulator one edge later

  logic [ACC_W-1:0] acc;  // phase accumulator

  // word selection, pins or bits as pin_mode says
  wire freq_pick  = ctrl.pin_mode ? pins_s.freq_pin : ctrl.freq_word_select_bit;
  wire phase_pick = ctrl.pin_mode ? pins_s.phase_pin : ctrl.phase_word_select_bit;
  wire [ACC_W-1:0] freq_sel  = freq_pick ? freq_b : freq_a;
  wire [PH_W-1:0]  phase_sel = phase_pick ? phase_b : phase_a;

  // modulo add drops the carry; switching words keeps phase continuous
  // the reset pin zeroes both stages, which the lookup turns
  // into a midscale dac code for as long as it is held
  wire [ACC_W-1:0] next_acc = pins_s.reset ? '0 : acc + freq_sel;
  wire [PH_W-1:0]  next_phase = pins_s.reset ? '0
                              : acc[ACC_W-1 -: PH_W] + phase_sel;

  // accumulator and phase offset stage on the master clock
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc     <= '0;
      phase_o <= '0;
    end else begin
      acc     <= next_acc;
      phase_o <= next_phase;
    end
  end

  // ---------------- dac sleep and logic output ----------------
  // the routing bit only matters while the pin is enabled;
  // a disabled pin idles low rather than floating

  wire nco_msb  = phase_o[PH_W-1];  // square wave at output rate
  wire comp_tie = ctrl.logic_output_enable & ctrl.logic_output_source;
  wire next_lo  = ctrl.logic_output_source ? pins_s.comp : nco_msb;

  // outputs registered; pin stays low while not driven
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dac_sleep_o            <= 1'b0;
      logic_out_o            <= 1'b0;
      logic_out_oe_o         <= 1'b0;
      comparator_input_pin_o <= 1'b0;
    end else begin
      dac_sleep_o            <= pins_s.sleep | ctrl.dac_powerdown_bit;
      logic_out_o            <= ctrl.logic_output_enable & next_lo;
      logic_out_oe_o         <= ctrl.logic_output_enable;
      comparator_input_pin_o <= comp_tie;
    end
  end

  // ---------------- avalon read path ----------------

  // status: reset pin, dac asleep, comparator, nco msb
  // all four are live views, nothing is latched
  wire [31:0] status_w = {28'h0, nco_msb, pins_s.comp, dac_sleep_o, pins_s.reset};

  // unmapped offsets read as zero, writes to them vanish
  wire [31:0] rd_mux =
      (avs_address_i == OFS_CTRL)    ? 32'(ctrl)    :
      (avs_address_i == OFS_FREQ_A)  ? 32'(freq_a)  :
      (avs_address_i == OFS_FREQ_B)  ? 32'(freq_b)  :
      (avs_address_i == OFS_PHASE_A) ? 32'(phase_a) :
      (avs_address_i == OFS_PHASE_B) ? 32'(phase_b) :
      (avs_address_i == OFS_STATUS)  ? status_w     : 32'h0;

  assign avs_waitrequest_o = req & ~ack;

  // one wait cycle keeps the read mux out of the bus path
  // trade: every access pays a cycle, reads and writes alike
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack            <= 1'b0;
      avs_readdata_o <= '0;
    end else begin
      ack <= bus_take;
      if (bus_take && avs_read_i) avs_readdata_o <= rd_mux;
    end
  end

  // ---------------- checks ----------------
  // all checks run on the master clock and rest in reset

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_freq_pick: assert property (
    ctrl.pin_mode |-> freq_sel == ($past(freq_word_select_pin_i, 2) ? freq_b : freq_a))
    else $error("frequency word not chosen by pin");
  a_acc_step: assert property (
    !$past(pins_s.reset) |-> acc == ACC_W'($past(acc) + $past(freq_sel)))
    else $error("accumulator did not add selected word");
  a_phase_add: assert property (
    !$past(pins_s.reset) |-> phase_o == PH_W'($past(acc[ACC_W-1 -: PH_W]) + $past(phase_sel)))
    else $error("phase offset not added to msbs");
  a_reset_clear: assert property (
    pins_s.reset |=> acc == '0 && phase_o == '0)
    else $error("reset pin did not clear datapath");
  a_regs_hold: assert property (
    pins_s.reset && !ser_valid && !bus_wr |=> $stable(ctrl) && $stable(freq_a)
      && $stable(freq_b) && $stable(phase_a) && $stable(phase_b))
    else $error("reset pin changed a host register");
  a_sleep_pin: assert property (
    pins_s.sleep |=> dac_sleep_o) else $error("sleep pin did not power down dac");
  a_sleep_or: assert property (
    ##1 dac_sleep_o == ($past(pins_s.sleep) || $past(ctrl.dac_powerdown_bit)))
    else $error("dac sleep not the or of pin and bit");
  a_oe_enable: assert property (
    !ctrl.logic_output_enable |=> !logic_out_oe_o && !logic_out_o)
    else $error("logic pin driven while disabled");
  a_src_select: assert property (
    ctrl.logic_output_enable && !ctrl.logic_output_source |=> logic_out_o == $past(nco_msb))
    else $error("logic pin not carrying nco msb");
  a_comp_tie: assert property (
    ##1 comparator_input_pin_o == $past(comp_tie) && (comparator_input_pin_o -> logic_out_oe_o))
    else $error("comparator input connection wrong");
  a_pin_sync: assert property (
    ##2 pins_s.freq_pin == $past(freq_word_select_pin_i, 2))
    else $error("select pin not two-stage sampled");
  a_phase_pick: assert property (
    ctrl.pin_mode |-> phase_sel == ($past(phase_word_select_pin_i, 2) ? phase_b : phase_a))
    else $error("phase word not chosen by pin");
  a_bit_mode: assert property (
    !ctrl.pin_mode |-> freq_sel == (ctrl.freq_word_select_bit ? freq_b : freq_a))
    else $error("frequency word not chosen by bit");
  a_comp_route: assert property (
    ctrl.logic_output_enable && ctrl.logic_output_source |=> logic_out_o == $past(pins_s.comp))
    else $error("logic pin not carrying comparator");
  a_serial_phase: assert property (
    ser_valid && ser_tgt == TGT_PHASE && !ser_pb |=> phase_a == $past(ser_word[PH_W-1:0]))
    else $error("serial phase word not loaded");
  a_one_wait: assert property (
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait cycle");

  // main scenarios the bench is expected to reach
  c_serial_word: cover property (ser_valid && ser_tgt == TGT_FREQ_A);
  c_pin_switch: cover property (ctrl.pin_mode && $changed(pins_s.freq_pin));
  c_comp_out: cover property (logic_out_oe_o && comparator_input_pin_o);
  c_reset_run: cover property (pins_s.reset ##1 !pins_s.reset ##3 acc != '0);

endmodule
`default_nettype wire

// ### dcp_top_test.sv
// self-checking bench of the dds control block
`timescale 1ns/1ps
`default_nettype none
module dcp_top_test;
  import dcp_pkg::*;
  // bus side, all idle at time zero
  logic             clk_i, rst_b_i = 1'b0;
  logic             avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [4:0]       avs_address_i = 5'h0;
  logic [31:0]      avs_writedata_i = 32'h0, avs_readdata_o;
  logic [3:0]       avs_byteenable_i = 4'hf;
  logic             avs_waitrequest_o;
  // pins and host model handshake
  logic             fpin = 1'b0, ppin = 1'b0, dres = 1'b0, slp = 1'b0, comp = 1'b0;
  logic             sclk, sdat, fsn, h_busy, h_go = 1'b0;
  logic [15:0]      h_word = 16'h0;
  logic [4:0]       h_nb = 5'd16;
  logic [PH_W-1:0]  phase_o;
  logic             dac_sleep_o, logic_out_o, logic_out_oe_o, comparator_input_pin_o;
  // expected register contents
  logic [27:0]      fa = 28'h0, fb = 28'h0;
  logic [11:0]      pa = 12'h0, pb = 12'h0, sa, sb;
  logic [31:0]      ctl = 32'h0, seed = 32'hba27bd1b, w;
  int               n_fail = 0, num_checks = 0, cyc = 0;

  dcp_top u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .freq_word_select_pin_i(fpin), .phase_word_select_pin_i(ppin), .dds_reset_i(dres), .sleep_i(slp),
    .serial_clk_i(sclk), .serial_data_in_i(sdat), .frame_sync_n_i(fsn), .comparator_result_i(comp),
    .phase_o(phase_o), .dac_sleep_o(dac_sleep_o), .logic_out_o(logic_out_o),
    .logic_out_oe_o(logic_out_oe_o), .comparator_input_pin_o(comparator_input_pin_o)
  );

  dcp_host_model u_host (
    .clk_i(clk_i), .send_i(h_go), .word_i(h_word), .nbits_i(h_nb),
    .sclk_o(sclk), .serial_data_o(sdat), .frame_sync_n_o(fsn), .busy_o(h_busy)
  );

  // 250 mhz master clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // hang guard, the whole run needs well under 20000 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // lfsr stream, repeatable from the fixed seed
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed;
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr_n, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= wr_n;
    avs_read_i <= !wr_n;
    // no local limit: a slave that never answers runs into the hang guard
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    check(nm, q, e);
  endtask

  // compares every host register with the bench copy
  task automatic rall();
    rchk("ctrl", OFS_CTRL, ctl);
    rchk("freq_a", OFS_FREQ_A, {4'h0, fa});
    rchk("freq_b", OFS_FREQ_B, {4'h0, fb});
    rchk("phase_a", OFS_PHASE_A, {20'h0, pa});
    rchk("phase_b", OFS_PHASE_B, {20'h0, pb});
  endtask

  task automatic setc(input logic [31:0] v);
    ctl = v;
    wr(OFS_CTRL, v);
    idle(6);
  endtask

  // phase advance over one clock; low freq bits are zero so it is exact
  task automatic step_chk(input logic [11:0] e);
    logic [11:0] p0, d;
    @(negedge clk_i);
    p0 = phase_o;
    @(negedge clk_i);
    d = phase_o - p0;
    check("phase_step", {20'h0, d}, {20'h0, e});
    @(posedge clk_i);
  endtask

  task automatic pchk(input logic [11:0] e);
    @(negedge clk_i);
    check("phase", {20'h0, phase_o}, {20'h0, e});
    @(posedge clk_i);
  endtask

  // serial frame, then the expected register update on a whole word only
  task automatic send(input logic [15:0] sw, input logic [4:0] nb);
    @(posedge clk_i);
    h_word <= sw;
    h_nb <= nb;
    h_go <= 1'b1;
    @(posedge clk_i);
    h_go <= 1'b0;
    do begin
      @(posedge clk_i);
    end while (h_busy !== 1'b0);
    idle(8);
    if (nb == 5'd16) begin
      case (sw[TGT_POS +: 2])
        TGT_CTRL:   ctl = {25'h0, sw[6:0]};
        TGT_FREQ_A: fa = ctl[6] ? {sw[13:0], fa[13:0]} : {fa[27:14], sw[13:0]};
        TGT_FREQ_B: fb = ctl[6] ? {sw[13:0], fb[13:0]} : {fb[27:14], sw[13:0]};
        default:    {pb, pa} = sw[PH_SEL_POS] ? {sw[11:0], pa} : {pb, sw[11:0]};
      endcase
    end
  endtask

  // main sequence
  initial begin
    idle(16);
    rst_b_i <= 1'b1;
    for (int a = 0; a < 7; a++) rchk("reset_value", 5'(a * 4), 32'h0);
    wr(OFS_STATUS, 32'hffffffff);
    wr(5'h18, 32'hffffffff);
    rchk("status_ro", OFS_STATUS, 32'h0);
    rchk("unmapped", 5'h18, 32'h0);
    // random words, upper bits dropped, one lane-masked write
    w = rnd();
    fa = w[27:0];
    wr(OFS_FREQ_A, w);
    pb = 12'(rnd());
    wr(OFS_PHASE_B, {20'h0, pb});
    w = rnd();
    wr(OFS_FREQ_B, w, 4'h2);
    fb[15:8] = w[15:8];
    rall();
    // accumulator step from the chosen frequency word
    sa = 12'(rnd());
    sb = 12'(rnd());
    fa = {sa, 16'h0};
    fb = {sb, 16'h0};
    wr(OFS_FREQ_A, {4'h0, fa});
    wr(OFS_FREQ_B, {4'h0, fb});
    setc(32'h0);
    step_chk(sa);
    setc(32'h1);
    step_chk(sa);
    fpin <= 1'b1;
    idle(6);
    step_chk(sb);
    fpin <= 1'b0;
    setc(32'h2);
    step_chk(sb);
    // reset pin zeroes the datapath but keeps every register
    dres <= 1'b1;
    idle(6);
    step_chk(12'h0);
    rall();
    fa = 28'h0;
    fb = 28'h0;
    pa = 12'(rnd());
    wr(OFS_FREQ_A, 32'h0);
    wr(OFS_FREQ_B, 32'h0);
    wr(OFS_PHASE_A, {20'h0, pa});
    dres <= 1'b0;
    idle(6);
    pchk(pa);
    setc(32'h1);
    ppin <= 1'b1;
    idle(6);
    pchk(pb);
    ppin <= 1'b0;
    setc(32'h4);
    pchk(pb);
    // sleep pin and bit, logic output enable and source, all combinations
    for (int k = 0; k < 16; k++) begin
      w = rnd();
      slp <= k[0];
      comp <= w[0];
      setc({26'h0, 3'(k >> 1), 3'h0});
      @(negedge clk_i);
      check("dac_sleep", {31'h0, dac_sleep_o}, 32'(k[0] | k[1]));
      check("logic_oe", {31'h0, logic_out_oe_o}, 32'(k[2]));
      check("cmp_pin", {31'h0, comparator_input_pin_o}, 32'(k[2] & k[3]));
      check("logic_out", {31'h0, logic_out_o}, 32'(k[2] & (k[3] ? w[0] : pa[11])));
      @(posedge clk_i);
    end
    // serial words to every target, one frame cut short
    for (int i = 0; i < 12; i++) begin
      w = rnd();
      w[15:14] = 2'(i);
      send(w[15:0], (i == 6) ? 5'd10 : 5'd16);
      rall();
    end
    give_verdict();
  end
endmodule
`default_nettype wire
